// ===== inc/pmx_pkg.sv
/*
  constants, field layouts and carrier structs for the seven-line pin port with function mux.
  assumes a single 250 MHz clock, synchronous active-high reset and an avalon-mm register slave.
*/
package pmx_pkg;
  localparam int         PMX_PINS       = 7;
  localparam int         PMX_AW         = 6;
  // byte offsets of the register map
  localparam logic [5:0] PMX_A_DIR      = 6'h00;
  localparam logic [5:0] PMX_A_IN       = 6'h04;
  localparam logic [5:0] PMX_A_OUT      = 6'h08;
  localparam logic [5:0] PMX_A_DEB      = 6'h0c;
  localparam logic [5:0] PMX_A_GEN      = 6'h10;
  localparam logic [5:0] PMX_A_CLR      = 6'h14;
  localparam logic [5:0] PMX_A_SET      = 6'h18;
  localparam logic [5:0] PMX_A_PULL1    = 6'h1c;
  localparam logic [5:0] PMX_A_PULL2    = 6'h20;
  localparam logic [5:0] PMX_A_OD       = 6'h24;
  localparam logic [5:0] PMX_A_FSEL1    = 6'h28;
  localparam logic [5:0] PMX_A_FSEL2    = 6'h2c;
  localparam logic [5:0] PMX_A_RISE     = 6'h30;
  localparam logic [5:0] PMX_A_FALL     = 6'h34;
  localparam logic [5:0] PMX_A_MASK     = 6'h38;
  localparam logic [5:0] PMX_A_STAT     = 6'h3c;
  // reset values
  localparam logic [7:0] PMX_RST_ZERO   = 8'h00;
  localparam logic [7:0] PMX_RST_MASK   = 8'h7f;
  // debounce: time in microseconds and derived cycle count at 250 MHz
  localparam int         PMX_DEB_US     = 1;
  localparam int         PMX_CLK_MHZ    = 250;
  localparam int         PMX_DEB_CYC    = PMX_DEB_US * PMX_CLK_MHZ;
  localparam int         PMX_DEB_W      = 8;
  // function select field: two bits per pin, fsel1 holds pins 0..3, fsel2 pins 4..6
  localparam int         PMX_FS_W       = 2;
  typedef enum logic [1:0] {
    PMX_FN_GPIO = 2'b00,
    PMX_FN_ALT1 = 2'b01,
    PMX_FN_ALT2 = 2'b10,
    PMX_FN_ALT3 = 2'b11
  } pmx_fn_e;
  // pad drive carrier
  typedef struct packed {
    logic [6:0] o;
    logic [6:0] oe;
    logic [6:0] pu;
    logic [6:0] pd;
  } pmx_pad_s;
  // secondary function inputs seen by the rest of the device
  typedef struct packed {
    logic power_down_input;
    logic peripheral_request_1;
    logic peripheral_request_2;
    logic reset_input;
    logic warm_reset_input;
    logic bus_supply_sense;
    logic switcher_clock_sync_input;
    logic hold_power_input;
    logic sleep_request_input;
    logic second_port_data_in;
    logic second_port_clock_in;
  } pmx_alt_in_s;
  // secondary function outputs from the rest of the device
  typedef struct packed {
    logic ext_regulator_enable_1;
    logic ext_regulator_enable_2;
    logic ext_regulator_enable_3;
    logic outputs_valid_indicator;
    logic second_port_data_o;
    logic second_port_data_oe;
    logic second_port_clock_o;
    logic second_port_clock_oe;
  } pmx_alt_out_s;
  // secondary line configuration held elsewhere in the device
  typedef struct packed {
    logic [6:0] pu;
    logic [6:0] pd;
    logic [6:0] od;
  } pmx_alt_cfg_s;
endpackage

// ===== logic/pmx_top.sv
/*
  seven-line pin port: primary gpio registers, secondary function mux, edge events.
  assumes pad inputs synchronous to sys_clk, an avalon-mm master and the power sequencer
  and serial port supplying secondary outputs and line configuration.
*/
`timescale 1ns/1ps
module pmx_top
  import pmx_pkg::*;
(
  input  wire logic                   sys_clk,          // 250 MHz clock
  input  wire logic                   rst,              // sync reset, active high
  input  wire logic [PMX_AW-1:0]      avs_address,      // byte address
  input  wire logic                   avs_read,         // read request
  input  wire logic                   avs_write,        // write request
  input  wire logic [31:0]            avs_writedata,    // write data
  input  wire logic [3:0]             avs_byteenable,   // byte lanes
  output logic      [31:0]            avs_readdata,     // read data
  output logic                        avs_waitrequest,  // stall
  input  wire logic [PMX_PINS-1:0]    pad_i,            // pad input levels
  output logic      [PMX_PINS-1:0]    pad_o,            // pad output levels
  output logic      [PMX_PINS-1:0]    pad_oe,           // pad output enable
  output logic      [PMX_PINS-1:0]    pad_pu,           // pullup enable
  output logic      [PMX_PINS-1:0]    pad_pd,           // pulldown enable
  input  wire pmx_alt_out_s           alt_out,          // secondary outputs
  input  wire pmx_alt_cfg_s           alt_cfg,          // secondary line config
  output pmx_alt_in_s                 alt_in_ff,        // secondary inputs
  output logic      [PMX_PINS-1:0]    pin_event_ff,     // pending pin events
  output logic      [PMX_PINS-1:0]    wake_event_ff,    // wake pulse per pin
  output logic                        switch_on_req_ff  // switch-on from off
);

  logic [7:0]            pin_direction_ff;
  logic [7:0]            pin_output_value_ff;
  logic [7:0]            pin_debounce_enable_ff;
  logic [7:0]            pin_global_enable_ff;
  logic [7:0]            pin_pull_config_1_ff;
  logic [7:0]            pin_pull_config_2_ff;
  logic [7:0]            pin_open_drain_enable_ff;
  logic [7:0]            function_select_1_ff;
  logic [7:0]            function_select_2_ff;
  logic [7:0]            rise_detect_config_ff;
  logic [7:0]            fall_detect_config_ff;
  logic [7:0]            pin_event_mask_ff;
  logic [PMX_PINS-1:0]   level_ff;
  logic [PMX_PINS-1:0]   level_d_ff;
  logic [PMX_PINS-1:0]   raw_d_ff;
  logic [PMX_PINS-1:0]   is_gpio;
  logic [PMX_PINS-1:0]   rise_ev;
  logic [PMX_PINS-1:0]   fall_ev;
  logic [PMX_PINS-1:0]   hit;
  logic [PMX_PINS-1:0]   stat_clr;
  logic [PMX_PINS-1:0]   gpio_drive;
  logic [PMX_PINS-1:0]   gpio_oe;
  logic [PMX_PINS-1:0]   gpio_o;
  logic [PMX_PINS-1:0]   alt_drv_oe;
  logic [PMX_PINS-1:0]   alt_drv_o;
  logic [PMX_PINS-1:0]   nxt_pad_oe;
  logic [PMX_PINS-1:0]   nxt_pad_o;
  logic [PMX_PINS-1:0]   nxt_pad_pu;
  logic [PMX_PINS-1:0]   nxt_pad_pd;
  logic [PMX_DEB_W-1:0]  deb_cnt_ff [PMX_PINS];
  logic [2*PMX_PINS-1:0] fsel_all;
  logic [7:0]            rd_mux;
  logic [7:0]            wdata;
  logic                  wr_go;
  logic                  rd_go;
  logic                  acc_done_ff;
  pmx_alt_in_s           nxt_alt_in;

  localparam logic [PMX_DEB_W-1:0] DEB_LAST = PMX_DEB_W'(PMX_DEB_CYC - 1);

  // one wait state per access; a write lands only at the edge that sees waitrequest low,
  // so a master that gives up early never leaves a half-done write behind
  assign wr_go = avs_write & acc_done_ff;
  assign rd_go = avs_read & ~acc_done_ff;
  assign wdata = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_done_ff     <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      acc_done_ff     <= (avs_read | avs_write) & ~acc_done_ff;
      avs_waitrequest <= ~((avs_read | avs_write) & ~acc_done_ff);
    end
  end

  // writable control registers; byte lane 0 carries every register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_direction_ff         <= PMX_RST_ZERO;
      pin_debounce_enable_ff   <= PMX_RST_ZERO;
      pin_global_enable_ff     <= PMX_RST_ZERO;
      pin_pull_config_1_ff     <= PMX_RST_ZERO;
      pin_pull_config_2_ff     <= PMX_RST_ZERO;
      pin_open_drain_enable_ff <= PMX_RST_ZERO;
      function_select_1_ff     <= PMX_RST_ZERO;
      function_select_2_ff     <= PMX_RST_ZERO;
      rise_detect_config_ff    <= PMX_RST_ZERO;
      fall_detect_config_ff    <= PMX_RST_ZERO;
      pin_event_mask_ff        <= PMX_RST_MASK;
    end else if (wr_go && avs_byteenable[0]) begin
      unique case (avs_address)
        PMX_A_DIR:   pin_direction_ff         <= wdata;
        PMX_A_DEB:   pin_debounce_enable_ff   <= wdata;
        PMX_A_GEN:   pin_global_enable_ff     <= wdata;
        PMX_A_PULL1: pin_pull_config_1_ff     <= wdata;
        PMX_A_PULL2: pin_pull_config_2_ff     <= wdata;
        PMX_A_OD:    pin_open_drain_enable_ff <= wdata;
        PMX_A_FSEL1: function_select_1_ff     <= wdata;
        PMX_A_FSEL2: function_select_2_ff     <= wdata;
        PMX_A_RISE:  rise_detect_config_ff    <= wdata;
        PMX_A_FALL:  fall_detect_config_ff    <= wdata;
        PMX_A_MASK:  pin_event_mask_ff        <= wdata;
        default:     ;
      endcase
    end
  end

  // output value: plain write, or atomic set/clear where zero bits keep their value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_output_value_ff <= PMX_RST_ZERO;
    end else if (wr_go && avs_byteenable[0]) begin
      if (avs_address == PMX_A_OUT) begin
        pin_output_value_ff <= wdata;
      end else if (avs_address == PMX_A_SET) begin
        pin_output_value_ff <= pin_output_value_ff | wdata;
      end else if (avs_address == PMX_A_CLR) begin
        pin_output_value_ff <= pin_output_value_ff & ~wdata;
      end
    end
  end

  // read mux; set/clear read as zero, unmapped reads zero
  always_comb begin
    unique case (avs_address)
      PMX_A_DIR:   rd_mux = pin_direction_ff;
      PMX_A_IN:    rd_mux = {1'b0, level_ff & ~pin_direction_ff[6:0]};
      PMX_A_OUT:   rd_mux = pin_output_value_ff;
      PMX_A_DEB:   rd_mux = pin_debounce_enable_ff;
      PMX_A_GEN:   rd_mux = pin_global_enable_ff;
      PMX_A_PULL1: rd_mux = pin_pull_config_1_ff;
      PMX_A_PULL2: rd_mux = pin_pull_config_2_ff;
      PMX_A_OD:    rd_mux = pin_open_drain_enable_ff;
      PMX_A_FSEL1: rd_mux = function_select_1_ff;
      PMX_A_FSEL2: rd_mux = function_select_2_ff;
      PMX_A_RISE:  rd_mux = rise_detect_config_ff;
      PMX_A_FALL:  rd_mux = fall_detect_config_ff;
      PMX_A_MASK:  rd_mux = pin_event_mask_ff;
      PMX_A_STAT:  rd_mux = {1'b0, pin_event_ff};
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0;
    end else if (rd_go) begin
      avs_readdata <= {24'h0, rd_mux};
    end
  end

  // two-bit function code per pin; zero selects the general purpose function
  assign fsel_all = {function_select_2_ff[5:0], function_select_1_ff};
  always_comb begin
    for (int i = 0; i < PMX_PINS; i++) begin
      is_gpio[i] = (fsel_all[PMX_FS_W*i +: PMX_FS_W] == PMX_FN_GPIO);
    end
  end

  // per-pin debounce on general purpose pins: the level follows the pad only once it has held steady
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      raw_d_ff <= '0;
      level_ff <= '0;
      for (int i = 0; i < PMX_PINS; i++) begin
        deb_cnt_ff[i] <= '0;
      end
    end else begin
      raw_d_ff <= pad_i;
      for (int i = 0; i < PMX_PINS; i++) begin
        if (!pin_debounce_enable_ff[i] || !is_gpio[i]) begin
          level_ff[i]   <= pad_i[i];
          deb_cnt_ff[i] <= '0;
        end else if (pad_i[i] != raw_d_ff[i]) begin
          deb_cnt_ff[i] <= '0;
        end else if (deb_cnt_ff[i] == DEB_LAST) begin
          level_ff[i]   <= raw_d_ff[i];
        end else begin
          deb_cnt_ff[i] <= deb_cnt_ff[i] + PMX_DEB_W'(1);
        end
      end
    end
  end

  // edges on the filtered level, qualified by function, global enable and edge config
  assign rise_ev = level_ff & ~level_d_ff & rise_detect_config_ff[6:0];
  assign fall_ev = ~level_ff & level_d_ff & fall_detect_config_ff[6:0];
  assign hit = (rise_ev | fall_ev) & is_gpio & pin_global_enable_ff[6:0];

  // clear-on-write of one bits; a new event in the same cycle wins over the clear
  assign stat_clr = (wr_go && avs_byteenable[0] && avs_address == PMX_A_STAT) ?
                    wdata[6:0] : '0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_d_ff    <= '0;
      pin_event_ff  <= '0;
      wake_event_ff <= '0;
    end else begin
      level_d_ff    <= level_ff;
      // masked events are dropped, not stored for later
      pin_event_ff  <= (pin_event_ff & ~stat_clr) | (hit & ~pin_event_mask_ff[6:0]);
      wake_event_ff <= hit;
    end
  end

  // pins 2 and 4 sit in the io supply domain and cannot switch the device on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      switch_on_req_ff <= 1'b0;
    end else begin
      switch_on_req_ff <= |(hit & 7'h6b);
    end
  end

  // secondary drive per pin; function codes follow the order of each pin's list
  always_comb begin
    alt_drv_oe = '0;
    alt_drv_o  = '0;
    // pin 0: code 3 is regulator enable 1
    if (fsel_all[1:0] == PMX_FN_ALT3) begin
      alt_drv_oe[0] = 1'b1;
      alt_drv_o[0]  = alt_out.ext_regulator_enable_1;
    end
    // pin 2: code 2 is the second port data line, driven by that port
    if (fsel_all[5:4] == PMX_FN_ALT2) begin
      alt_drv_oe[2] = alt_out.second_port_data_oe;
      alt_drv_o[2]  = alt_out.second_port_data_o;
    end
    // pin 3: code 2 is regulator enable 1
    if (fsel_all[7:6] == PMX_FN_ALT2) begin
      alt_drv_oe[3] = 1'b1;
      alt_drv_o[3]  = alt_out.ext_regulator_enable_1;
    end
    // pin 4: code 1 regulator enable 2, code 2 second port clock line
    if (fsel_all[9:8] == PMX_FN_ALT1) begin
      alt_drv_oe[4] = 1'b1;
      alt_drv_o[4]  = alt_out.ext_regulator_enable_2;
    end else if (fsel_all[9:8] == PMX_FN_ALT2) begin
      alt_drv_oe[4] = alt_out.second_port_clock_oe;
      alt_drv_o[4]  = alt_out.second_port_clock_o;
    end
    // pin 5: code 2 regulator enable 3
    if (fsel_all[11:10] == PMX_FN_ALT2) begin
      alt_drv_oe[5] = 1'b1;
      alt_drv_o[5]  = alt_out.ext_regulator_enable_3;
    end
    // pin 6: code 2 outputs valid, code 3 regulator enable 3
    if (fsel_all[13:12] == PMX_FN_ALT2) begin
      alt_drv_oe[6] = 1'b1;
      alt_drv_o[6]  = alt_out.outputs_valid_indicator;
    end else if (fsel_all[13:12] == PMX_FN_ALT3) begin
      alt_drv_oe[6] = 1'b1;
      alt_drv_o[6]  = alt_out.ext_regulator_enable_3;
    end
  end

  // primary drive: open drain only pulls low, releasing the line for a one
  assign gpio_drive = pin_direction_ff[6:0] & pin_global_enable_ff[6:0];
  assign gpio_oe = gpio_drive & (~pin_open_drain_enable_ff[6:0] |
                                 ~pin_output_value_ff[6:0]);
  assign gpio_o  = pin_output_value_ff[6:0] & ~pin_open_drain_enable_ff[6:0];

  // pad controls: secondary pins take only their own config set
  always_comb begin
    for (int i = 0; i < PMX_PINS; i++) begin
      if (is_gpio[i]) begin
        nxt_pad_oe[i] = gpio_oe[i];
        nxt_pad_o[i]  = gpio_o[i];
        nxt_pad_pu[i] = pin_pull_config_1_ff[i];
        nxt_pad_pd[i] = pin_pull_config_2_ff[i] & ~pin_pull_config_1_ff[i];
      end else begin
        nxt_pad_oe[i] = alt_drv_oe[i] & ~(alt_cfg.od[i] & alt_drv_o[i]);
        nxt_pad_o[i]  = alt_drv_o[i] & ~alt_cfg.od[i];
        nxt_pad_pu[i] = alt_cfg.pu[i];
        nxt_pad_pd[i] = alt_cfg.pd[i] & ~alt_cfg.pu[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pad_oe <= '0;
      pad_o  <= '0;
      pad_pu <= '0;
      pad_pd <= '0;
    end else begin
      pad_oe <= nxt_pad_oe;
      pad_o  <= nxt_pad_o;
      pad_pu <= nxt_pad_pu;
      pad_pd <= nxt_pad_pd;
    end
  end

  // secondary inputs: idle high for active-low style inputs is left to the consumer
  always_comb begin
    nxt_alt_in = '0;
    nxt_alt_in.power_down_input          = (fsel_all[1:0] == PMX_FN_ALT1) & level_ff[0];
    nxt_alt_in.peripheral_request_2      = ((fsel_all[1:0] == PMX_FN_ALT2) & level_ff[0]) |
                                           ((fsel_all[7:6] == PMX_FN_ALT1) & level_ff[3]);
    nxt_alt_in.reset_input               = (fsel_all[3:2] == PMX_FN_ALT1) & level_ff[1];
    nxt_alt_in.warm_reset_input          = (fsel_all[3:2] == PMX_FN_ALT2) & level_ff[1];
    nxt_alt_in.bus_supply_sense          = (fsel_all[3:2] == PMX_FN_ALT3) & level_ff[1];
    nxt_alt_in.peripheral_request_1      = (fsel_all[5:4] == PMX_FN_ALT1) & level_ff[2];
    nxt_alt_in.second_port_data_in       = (fsel_all[5:4] == PMX_FN_ALT2) & level_ff[2];
    nxt_alt_in.switcher_clock_sync_input = (fsel_all[7:6] == PMX_FN_ALT3) & level_ff[3];
    nxt_alt_in.second_port_clock_in      = (fsel_all[9:8] == PMX_FN_ALT2) & level_ff[4];
    nxt_alt_in.hold_power_input          = (fsel_all[11:10] == PMX_FN_ALT1) & level_ff[5];
    nxt_alt_in.sleep_request_input       = (fsel_all[13:12] == PMX_FN_ALT1) & level_ff[6];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      alt_in_ff <= '0;
    end else begin
      alt_in_ff <= nxt_alt_in;
    end
  end

endmodule

// ===== sim/pmx_monitor.sv
/*
  checker for the pin port: bus answer timing, read data, and causes of pad events.
  assumes it is bound to pmx_top, sees only its ports, and pad inputs are low in reset.
*/
`timescale 1ns/1ps
module pmx_monitor
  import pmx_pkg::*;
(
  input wire logic                sys_clk,          // clock
  input wire logic                rst,              // sync reset
  input wire logic                avs_read,         // read request
  input wire logic                avs_write,        // write request
  input wire logic [31:0]         avs_readdata,     // read data
  input wire logic                avs_waitrequest,  // stall
  input wire logic [PMX_PINS-1:0] pad_i,            // pad levels
  input wire logic [PMX_PINS-1:0] pad_pu,           // pullups
  input wire logic [PMX_PINS-1:0] pad_pd,           // pulldowns
  input wire logic [PMX_PINS-1:0] pin_event_ff,     // event status
  input wire logic [PMX_PINS-1:0] wake_event_ff,    // wake pulses
  input wire logic                switch_on_req_ff  // switch-on pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a fresh request while idle, and the single-cycle answer
  sequence req_rise;
    $rose(avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence ack_now;
    !avs_waitrequest;
  endsequence
  wait_answer_a: assert property (req_rise |=> ack_now)
    else $error("no answer one cycle after a request");
  ack_single_a: assert property (ack_now |=> avs_waitrequest)
    else $error("answer held longer than one cycle");
  ack_cause_a: assert property (ack_now |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  read_upper_a: assert property (ack_now and avs_read |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  read_hold_a: assert property ($changed(avs_readdata) |-> avs_read)
    else $error("read data moved without a read");
  // status may only set where the pad moved two edges earlier
  event_cause_a: assert property (((pin_event_ff & ~$past(pin_event_ff))
    & ~($past(pad_i, 2) ^ $past(pad_i, 3))) == 7'h00)
    else $error("status set without a pad edge");
  wake_cause_a: assert property ((wake_event_ff
    & ~($past(pad_i, 2) ^ $past(pad_i, 3))) == 7'h00)
    else $error("wake pulse without a pad edge");
  switch_on_a: assert property (switch_on_req_ff |->
    (($past(pad_i, 2) ^ $past(pad_i, 3)) & 7'h6b) != 7'h00)
    else $error("switch-on from a pin that may not request it");
  pull_cause_a: assert property ($changed({pad_pu, pad_pd}) |-> $past(avs_write, 2))
    else $error("pull setting moved without a write");
endmodule
bind pmx_top pmx_monitor i_mon (.sys_clk, .rst, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .pad_i, .pad_pu, .pad_pd, .pin_event_ff, .wake_event_ff, .switch_on_req_ff);

// ===== sim/pmx_board.sv
/*
  board-side model of the seven pad lines: own drive, board sources, pulls.
  assumes pad controls from the pin port and board sources set by the bench.
*/
`timescale 1ns/1ps
module pmx_board
  import pmx_pkg::*;
(
  input  wire logic                sys_clk, // clock
  input  wire logic [PMX_PINS-1:0] pad_o,   // port drive level
  input  wire logic [PMX_PINS-1:0] pad_oe,  // port drives line
  input  wire logic [PMX_PINS-1:0] pad_pu,  // pullup on
  input  wire logic [PMX_PINS-1:0] pad_pd,  // pulldown on
  input  wire logic [PMX_PINS-1:0] ext_val, // board source level
  input  wire logic [PMX_PINS-1:0] ext_en,  // board source on
  output logic      [PMX_PINS-1:0] pad_i    // resolved line level
);
  logic [PMX_PINS-1:0] last_ff;
  // a line nobody holds wanders each cycle, so stale values are never trusted
  always_comb begin
    for (int i = 0; i < PMX_PINS; i++) begin
      if (pad_oe[i])
        pad_i[i] = pad_o[i];
      else if (ext_en[i])
        pad_i[i] = ext_val[i];
      else if (pad_pu[i])
        pad_i[i] = 1'b1;
      else if (pad_pd[i])
        pad_i[i] = 1'b0;
      else
        pad_i[i] = ~last_ff[i];
    end
  end
  // previous level for the floating case
  always_ff @(posedge sys_clk) begin
    last_ff <= pad_i;
  end
endmodule

// ===== sim/test_pin_port_with_function_mux.sv
/*
  self-checking bench for the pin port: registers, set/clear, drive, events, mux.
  assumes pmx_top with its checker bound, and the board model on the pad side.
*/
`timescale 1ns/1ps
module test_pin_port_with_function_mux import pmx_pkg::*; ;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic [5:0]   avs_address = 6'h00;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  logic [6:0]   pad_i, pad_o, pad_oe, pad_pu, pad_pd, pin_event_ff, wake_event_ff;
  logic [6:0]   ext_val = 7'h00;
  logic [6:0]   ext_en = 7'h7f;
  logic         switch_on_req_ff;
  pmx_alt_out_s alt_out = '0;
  pmx_alt_cfg_s alt_cfg = '0;
  pmx_alt_in_s  alt_in_ff;
  int           fails = 0;
  int           n_compared = 0;
  int           mdl[16];
  logic [31:0]  seed = 32'hc0cf;
  logic [31:0]  rdv, r;
  logic [6:0]   p, wk;
  logic         so;
  logic [5:0]   rw_a[12] = '{PMX_A_DEB, PMX_A_DIR, PMX_A_OUT, PMX_A_GEN, PMX_A_PULL1,
    PMX_A_PULL2, PMX_A_OD, PMX_A_FSEL1, PMX_A_FSEL2, PMX_A_RISE, PMX_A_FALL, PMX_A_MASK};
  logic [7:0]   rw_m[12] = '{8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'hff,
    8'h3f, 8'h7f, 8'h7f, 8'h7f};
  // free-running 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  pmx_top i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu), .pad_pd(pad_pd),
    .alt_out(alt_out), .alt_cfg(alt_cfg), .alt_in_ff(alt_in_ff), .pin_event_ff(pin_event_ff),
    .wake_event_ff(wake_event_ff), .switch_on_req_ff(switch_on_req_ff));
  pmx_board i_board (.sys_clk(sys_clk), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .pad_pd(pad_pd), .ext_val(ext_val), .ext_en(ext_en), .pad_i(pad_i));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon access: held until waitrequest is sampled low, then released
  task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= !wr;
    avs_write <= wr;
    // no cycle count is assumed here; only the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // write and keep the register model in step
  task mwr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (a == PMX_A_SET) mdl[2] = mdl[2] | d;
    else if (a == PMX_A_CLR) mdl[2] = mdl[2] & ~d;
    else mdl[a >> 2] = d;
  endtask
  task rdc(input string nm, input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, rdv, {24'h0, exp});
  endtask
  task settle;
    repeat (6) @(posedge sys_clk);
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #(4 * 20000);
    fails++;
    conclude();
  end
  initial begin
    r = xs();
    @(posedge sys_clk);
    alt_cfg <= r[20:0];
    alt_out <= r[28:21];
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 12; i++) rdc("reset", rw_a[i], rw_a[i] == PMX_A_MASK ? 8'h7f : 8'h00);
    rdc("in_reset", PMX_A_IN, 8'h00);
    $display("test reset_values done");
    // debounce is undone at once so pad timing stays fixed for later tests
    for (int i = 0; i < 12; i++) begin
      r = xs();
      mwr(rw_a[i], r[7:0] & rw_m[i]);
      rdc("rw", rw_a[i], mdl[rw_a[i] >> 2]);
      if (rw_a[i] == PMX_A_DEB) mwr(PMX_A_DEB, 8'h00);
    end
    rdc("set_rd", PMX_A_SET, 8'h00);
    rdc("clr_rd", PMX_A_CLR, 8'h00);
    $display("test read_write done");
    mwr(PMX_A_FSEL1, 8'h00);
    mwr(PMX_A_FSEL2, 8'h00);
    mwr(PMX_A_OD, 8'h00);
    mwr(PMX_A_MASK, 8'h7f);
    mwr(PMX_A_DIR, 8'h7f);
    mwr(PMX_A_GEN, 8'h7f);
    mwr(PMX_A_OUT, 8'h55);
    foreach (rw_m[i]) begin
      if (i < 4) begin
        mwr(i[0] ? PMX_A_CLR : PMX_A_SET, i < 2 ? (i[0] ? 8'h41 : 8'h0a) : 8'h00);
        rdc("set_clr", PMX_A_OUT, mdl[2]);
      end
    end
    settle();
    chk("pad_o", pad_o, mdl[2]);
    chk("pad_oe", pad_oe, 7'h7f);
    chk("pad_i", pad_i, mdl[2]);
    chk("pad_pu", pad_pu, mdl[7]);
    chk("pad_pd", pad_pd, mdl[8] & ~mdl[7] & 7'h7f);
    rdc("in_out", PMX_A_IN, 8'h00);
    mwr(PMX_A_OD, 8'h0f);
    settle();
    chk("od_oe", pad_oe, 7'h7f & ~(7'h0f & mdl[2]));
    mwr(PMX_A_GEN, 8'h00);
    settle();
    chk("gen_off", pad_oe, 7'h00);
    $display("test output_drive done");
    mwr(PMX_A_GEN, 8'h7f);
    mwr(PMX_A_OD, 8'h00);
    mwr(PMX_A_DIR, 8'h00);
    mwr(PMX_A_RISE, 8'h7f);
    mwr(PMX_A_FALL, 8'h00);
    mwr(PMX_A_STAT, 8'h7f);
    mwr(PMX_A_MASK, 8'h00);
    r = xs();
    p = r[6:0] | 7'h01;
    wk = 7'h00;
    so = 1'b0;
    @(posedge sys_clk);
    ext_val <= p;
    // pulses last one cycle, so they are gathered mid-cycle where they are settled
    repeat (6) begin
      @(negedge sys_clk);
      wk = wk | wake_event_ff;
      so = so | switch_on_req_ff;
    end
    chk("wake", wk, p);
    chk("switch_on", so, |(p & 7'h6b));
    rdc("in_level", PMX_A_IN, p);
    rdc("rise_stat", PMX_A_STAT, p);
    mwr(PMX_A_STAT, 8'h7f);
    rdc("stat_clr", PMX_A_STAT, 8'h00);
    mwr(PMX_A_FALL, 8'h7f);
    mwr(PMX_A_RISE, 8'h00);
    mwr(PMX_A_MASK, 8'h7f);
    @(posedge sys_clk);
    ext_val <= 7'h00;
    settle();
    mwr(PMX_A_MASK, 8'h00);
    rdc("masked", PMX_A_STAT, 8'h00);
    mwr(PMX_A_RISE, 8'h7f);
    mwr(PMX_A_FSEL1, 8'h01);
    @(posedge sys_clk);
    ext_val <= 7'h01;
    settle();
    chk("alt_pd", alt_in_ff.power_down_input, 1'b1);
    rdc("alt_stat", PMX_A_STAT, 8'h00);
    $display("test pin_events done");
    conclude();
  end
endmodule
